// ### rtl/lcc_regs.sv
// per-channel line configuration register bank with an axi4-lite slave
// assumes pins arrive asynchronously and the timer tick comes from logic on aclk
//
// Overview of operation
// - writing one to reset bit resets channel
// - channel reset completes within one microsecond
// - reset bit clears itself when done
// - standard bit: zero T1/J1, one E1
// - standard bit used only with pin low
// - channel reset keeps the standard bit
// - attenuators run only when enabled, default off
// - transmit enable gates transmit attenuator alone
// - depth code: 128, 64, else 32 bits
// - limit adjusts rate two bits from edges
// - wide bandwidth: 5 Hz or 6.77 Hz
// - narrow bandwidth: 1.26 Hz or 0.87 Hz
// - registers read-write, reset to zero
// - copies every 40H, channel zero high
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module lcc_regs #(
   parameter int NUM_CH = 22
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [lcc_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [lcc_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [lcc_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [lcc_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // standard select pins and timer event
   input wire logic standard_select_hw_enable_pin,
   input wire logic standard_select_hw_e1_pin,
   input wire logic second_timer_tick,
   // per-channel state
   output logic [NUM_CH-1:0] ch_soft_reset,
   output logic [NUM_CH-1:0] ch_e1_mode,
   // transmit attenuator controls
   output logic [NUM_CH-1:0] tx_atten_enable,
   output logic [NUM_CH-1:0] tx_atten_limit_enable,
   output logic [NUM_CH*8-1:0] tx_atten_fifo_depth,
   output logic [NUM_CH*8-1:0] tx_atten_high_mark,
   output logic [NUM_CH*8-1:0] tx_atten_low_mark,
   output logic [NUM_CH*10-1:0] tx_atten_corner,
   // receive attenuator controls
   output logic [NUM_CH-1:0] rx_atten_enable,
   output logic [NUM_CH-1:0] rx_atten_limit_enable,
   output logic [NUM_CH*8-1:0] rx_atten_fifo_depth,
   output logic [NUM_CH*8-1:0] rx_atten_high_mark,
   output logic [NUM_CH*8-1:0] rx_atten_low_mark,
   output logic [NUM_CH*10-1:0] rx_atten_corner
);
   import lcc_pkg::*;

   // refuse channel counts the address decode cannot serve
   // a five-bit block field limits how many copies fit
   if (NUM_CH < 2 || NUM_CH > MAX_CH) begin : g_num_ch_check
      $error("lcc_regs: NUM_CH must lie between 2 and 22");
   end

   // pin synchronisers
   logic hw_en_meta_q;
   logic hw_en_q;
   logic hw_e1_meta_q;
   logic hw_e1_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hw_en_meta_q <= 1'b0;
         hw_en_q <= 1'b0;
         hw_e1_meta_q <= 1'b0;
         hw_e1_q <= 1'b0;
      end else begin
         hw_en_meta_q <= standard_select_hw_enable_pin;
         hw_en_q <= hw_en_meta_q;
         hw_e1_meta_q <= standard_select_hw_e1_pin;
         hw_e1_q <= hw_e1_meta_q;
      end
   end

   // address decode
   function automatic logic [5:0] chan_of(input logic [ADDR_W-1:0] addr);
      logic [10:0] idx;
      logic [4:0] blk;
      idx = addr[ADDR_W-1:2];
      blk = idx[10:6];
      chan_of = 6'h3F;
      if (idx[10:6] == CH0_BASE[10:6]) begin
         chan_of = 6'h00;
      end else if (32'(blk) < NUM_CH - 1) begin
         chan_of = 6'(blk) + 6'h01;
      end
   endfunction

   function automatic lcc_sel_t sel_of(input logic [ADDR_W-1:0] addr);
      logic [10:0] idx;
      idx = addr[ADDR_W-1:2];
      sel_of = LCC_SEL_NONE;
      if (idx == IDX_TIMER_IRQ) begin
         sel_of = LCC_SEL_TIMER;
      end else if (chan_of(addr) != 6'h3F) begin
         case (idx & (CH_STRIDE - 11'h001))
            IDX_CHAN_CFG: sel_of = LCC_SEL_CHANNEL_CONFIG;
            IDX_TX_JA: sel_of = LCC_SEL_TJA;
            IDX_RX_JA: sel_of = LCC_SEL_RJA;
            default: sel_of = LCC_SEL_NONE;
         endcase
      end
   endfunction

   // write channel: address and data taken in either order
   logic aw_held_q;
   logic w_held_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [7:0] wdata_q;
   logic wlane_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic wr_go;
   lcc_sel_t wr_sel;
   logic [5:0] wr_chan;
   logic wr_strobe;

   assign awready = !aw_held_q && !bvalid_q;
   assign wready = !w_held_q && !bvalid_q;
   assign wr_go = aw_held_q && w_held_q && !bvalid_q;
   assign wr_sel = sel_of(awaddr_q);
   assign wr_chan = chan_of(awaddr_q);
   // only byte lane zero carries register bits
   assign wr_strobe = wr_go && wlane_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q <= '0;
      end else if (awvalid && awready) begin
         aw_held_q <= 1'b1;
         awaddr_q <= awaddr;
      end else if (wr_go) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wdata_q <= 8'h00;
         wlane_q <= 1'b0;
      end else if (wvalid && wready) begin
         w_held_q <= 1'b1;
         wdata_q <= wdata[7:0];
         wlane_q <= wstrb[0];
      end else if (wr_go) begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= (wr_sel == LCC_SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign bvalid = bvalid_q;
   assign bresp = bresp_q;

   // one second timer flag: tick sets, writing one clears, set wins
   logic timer_flag_q;
   logic timer_clear;

   assign timer_clear = wr_strobe && wr_sel == LCC_SEL_TIMER && wdata_q[TIMER_FLAG_BIT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_flag_q <= 1'b0;
      end else if (second_timer_tick) begin
         timer_flag_q <= 1'b1;
      end else if (timer_clear) begin
         timer_flag_q <= 1'b0;
      end
   end

   // channel copies
   logic [7:0] channel_config_rd [NUM_CH];
   logic [7:0] tja_rd [NUM_CH];
   logic [7:0] rja_rd [NUM_CH];

   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic ch_wr;
      assign ch_wr = wr_strobe && wr_chan == 6'(c);
      lcc_chan u_chan (
         .aclk(aclk),
         .aresetn(aresetn),
         .wr_en(ch_wr),
         .wr_sel(wr_sel),
         .wr_data(wdata_q),
         .std_hw_en(hw_en_q),
         .std_hw_e1(hw_e1_q),
         .chan_cfg(channel_config_rd[c]),
         .tx_ja_cfg(tja_rd[c]),
         .rx_ja_cfg(rja_rd[c]),
         .soft_reset(ch_soft_reset[c]),
         .e1_mode(ch_e1_mode[c])
      );
      lcc_atten_decode u_tx (
         .aclk(aclk),
         .aresetn(aresetn),
         .cfg(tja_rd[c]),
         .e1_mode(ch_e1_mode[c]),
         .hold(ch_soft_reset[c]),
         .enable(tx_atten_enable[c]),
         .limit_enable(tx_atten_limit_enable[c]),
         .depth(tx_atten_fifo_depth[c*8 +: 8]),
         .high_mark(tx_atten_high_mark[c*8 +: 8]),
         .low_mark(tx_atten_low_mark[c*8 +: 8]),
         .corner_centihz(tx_atten_corner[c*10 +: 10])
      );
      lcc_atten_decode u_rx (
         .aclk(aclk),
         .aresetn(aresetn),
         .cfg(rja_rd[c]),
         .e1_mode(ch_e1_mode[c]),
         .hold(ch_soft_reset[c]),
         .enable(rx_atten_enable[c]),
         .limit_enable(rx_atten_limit_enable[c]),
         .depth(rx_atten_fifo_depth[c*8 +: 8]),
         .high_mark(rx_atten_high_mark[c*8 +: 8]),
         .low_mark(rx_atten_low_mark[c*8 +: 8]),
         .corner_centihz(rx_atten_corner[c*10 +: 10])
      );
   end

   // read channel: one outstanding read, data one cycle after the address
   logic rvalid_q;
   logic [DATA_W-1:0] rdata_q;
   logic [1:0] rresp_q;
   lcc_sel_t rd_sel;
   logic [5:0] rd_chan;
   logic [7:0] rd_byte;

   assign rd_sel = sel_of(araddr);
   assign rd_chan = chan_of(araddr);
   assign arready = !rvalid_q;

   always_comb begin
      rd_byte = 8'h00;
      for (int c = 0; c < NUM_CH; c++) begin
         if (rd_chan == 6'(c)) begin
            case (rd_sel)
               LCC_SEL_CHANNEL_CONFIG: rd_byte = channel_config_rd[c];
               LCC_SEL_TJA: rd_byte = tja_rd[c];
               LCC_SEL_RJA: rd_byte = rja_rd[c];
               default: rd_byte = 8'h00;
            endcase
         end
      end
      if (rd_sel == LCC_SEL_TIMER) begin
         rd_byte = {7'h00, timer_flag_q};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_q <= 1'b1;
         rdata_q <= {24'h000000, rd_byte};
         rresp_q <= (rd_sel == LCC_SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
endmodule

// ### rtl/lcc_pkg.sv
// shared constants and types for the line channel configuration registers
// assumes one 200 MHz clock; byte address of a register is four times its index
package lcc_pkg;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 32;
   localparam int MAX_CH = 22;
   // register indices; channel n>0 at (n-1)*stride, channel 0 at its own base
   localparam logic [10:0] IDX_CHAN_CFG = 11'h001;
   localparam logic [10:0] IDX_TX_JA = 11'h002;
   localparam logic [10:0] IDX_RX_JA = 11'h003;
   localparam logic [10:0] IDX_TIMER_IRQ = 11'h3C0;
   localparam logic [10:0] CH_STRIDE = 11'h040;
   localparam logic [10:0] CH0_BASE = 11'h7C0;
   // field positions
   localparam int CHANNEL_CONFIG_STD_BIT = 0;
   localparam int CHANNEL_CONFIG_RST_BIT = 1;
   localparam int JA_BW_BIT = 0;
   localparam int JA_DP_LSB = 1;
   localparam int JA_DP_MSB = 2;
   localparam int JA_EN_BIT = 3;
   localparam int JA_LIMIT_BIT = 4;
   localparam int TIMER_FLAG_BIT = 0;
   // writable masks, reset values
   localparam logic [7:0] CHANNEL_CONFIG_MASK = 8'h03;
   localparam logic [7:0] JA_MASK = 8'h1F;
   localparam logic [7:0] REG_RESET = 8'h00;
   // soft reset length: a longest time rounds down
   localparam int SOFT_RST_MAX_NS = 1;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int SOFT_RST_CYCLES = (SOFT_RST_MAX_NS * 1000 * 1000) / CLK_PERIOD_PS;
   localparam int SOFT_RST_CNT_W = $clog2(SOFT_RST_CYCLES + 1);
   // fifo depth in bits and limit margin
   localparam logic [7:0] DEPTH_128 = 8'h80;
   localparam logic [7:0] DEPTH_64 = 8'h40;
   localparam logic [7:0] DEPTH_32 = 8'h20;
   localparam logic [7:0] LIMIT_MARGIN = 8'h02;
   // corner frequencies in hundredths of a hertz
   localparam logic [9:0] CF_T1_WIDE = 10'h1F4;
   localparam logic [9:0] CF_E1_WIDE = 10'h2A5;
   localparam logic [9:0] CF_T1_NARROW = 10'h07E;
   localparam logic [9:0] CF_E1_NARROW = 10'h057;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   typedef enum logic [2:0] {
      LCC_SEL_NONE,
      LCC_SEL_CHANNEL_CONFIG,
      LCC_SEL_TJA,
      LCC_SEL_RJA,
      LCC_SEL_TIMER
   } lcc_sel_t;
   typedef enum logic {
      LCC_RST_IDLE,
      LCC_RST_BUSY
   } lcc_rst_state_t;
endpackage

// ### rtl/lcc_chan.sv
// one channel's copy of the configuration, receive and transmit attenuator registers
// assumes writes arrive as a one-cycle strobe from the bus slave on the same clock
`timescale 1ns/1ps
module lcc_chan (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register write strobe
   input wire logic wr_en,
   input wire lcc_pkg::lcc_sel_t wr_sel,
   input wire logic [7:0] wr_data,
   // synchronised standard pins
   input wire logic std_hw_en,
   input wire logic std_hw_e1,
   // register contents and derived state
   output logic [7:0] chan_cfg,
   output logic [7:0] tx_ja_cfg,
   output logic [7:0] rx_ja_cfg,
   output logic soft_reset,
   output logic e1_mode
);
   import lcc_pkg::*;
   lcc_rst_state_t rst_state_q;
   logic [SOFT_RST_CNT_W-1:0] rst_cnt_q;
   logic std_sel_q;
   logic [7:0] tx_ja_q;
   logic [7:0] rx_ja_q;
   logic rst_done;
   logic rst_start;

   assign rst_start = wr_en && wr_sel == LCC_SEL_CHANNEL_CONFIG && wr_data[CHANNEL_CONFIG_RST_BIT];
   assign rst_done = rst_state_q == LCC_RST_BUSY
      && rst_cnt_q == SOFT_RST_CNT_W'(SOFT_RST_CYCLES - 1);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rst_state_q <= LCC_RST_IDLE;
         rst_cnt_q <= '0;
      end else begin
         case (rst_state_q)
            LCC_RST_IDLE: begin
               rst_cnt_q <= '0;
               if (rst_start) begin
                  rst_state_q <= LCC_RST_BUSY;
               end
            end
            LCC_RST_BUSY: begin
               // a second start while busy is absorbed, not restarted
               rst_cnt_q <= rst_cnt_q + 1'b1;
               if (rst_done) begin
                  rst_state_q <= LCC_RST_IDLE;
               end
            end
            default: rst_state_q <= LCC_RST_IDLE;
         endcase
      end
   end

   // standard select survives the channel reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         std_sel_q <= REG_RESET[CHANNEL_CONFIG_STD_BIT];
      end else if (wr_en && wr_sel == LCC_SEL_CHANNEL_CONFIG) begin
         std_sel_q <= wr_data[CHANNEL_CONFIG_STD_BIT];
      end
   end

   // attenuator settings return to defaults when the channel reset ends
   always_ff @(posedge aclk) begin
      if (!aresetn || rst_done) begin
         tx_ja_q <= REG_RESET;
         rx_ja_q <= REG_RESET;
      end else if (wr_en) begin
         if (wr_sel == LCC_SEL_TJA) begin
            tx_ja_q <= wr_data & JA_MASK;
         end
         if (wr_sel == LCC_SEL_RJA) begin
            rx_ja_q <= wr_data & JA_MASK;
         end
      end
   end

   assign soft_reset = rst_state_q == LCC_RST_BUSY;
   assign chan_cfg = {6'h00, soft_reset, std_sel_q};
   assign tx_ja_cfg = tx_ja_q;
   assign rx_ja_cfg = rx_ja_q;
   assign e1_mode = std_hw_en ? std_hw_e1 : std_sel_q;
endmodule

// ### rtl/lcc_atten_decode.sv
// turns one attenuator setting into registered controls for the attenuator datapath
// assumes mode and setting come from the same clock domain
`timescale 1ns/1ps
module lcc_atten_decode (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // setting
   input wire logic [7:0] cfg,
   input wire logic e1_mode,
   input wire logic hold,
   // controls
   output logic enable,
   output logic limit_enable,
   output logic [7:0] depth,
   output logic [7:0] high_mark,
   output logic [7:0] low_mark,
   output logic [9:0] corner_centihz
);
   import lcc_pkg::*;
   logic [7:0] depth_d;
   logic [9:0] corner_d;

   always_comb begin
      case (cfg[JA_DP_MSB:JA_DP_LSB])
         2'h0: depth_d = DEPTH_128;
         2'h1: depth_d = DEPTH_64;
         default: depth_d = DEPTH_32;
      endcase
      case ({cfg[JA_BW_BIT], e1_mode})
         2'h0: corner_d = CF_T1_WIDE;
         2'h1: corner_d = CF_E1_WIDE;
         2'h2: corner_d = CF_T1_NARROW;
         default: corner_d = CF_E1_NARROW;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable <= 1'b0;
         limit_enable <= 1'b0;
         depth <= DEPTH_128;
         high_mark <= DEPTH_128 - LIMIT_MARGIN;
         low_mark <= LIMIT_MARGIN;
         corner_centihz <= CF_T1_WIDE;
      end else begin
         // held off during a channel reset so the fifo restarts clean
         enable <= cfg[JA_EN_BIT] && !hold;
         limit_enable <= cfg[JA_LIMIT_BIT] && cfg[JA_EN_BIT] && !hold;
         depth <= depth_d;
         high_mark <= depth_d - LIMIT_MARGIN;
         low_mark <= LIMIT_MARGIN;
         corner_centihz <= corner_d;
      end
   end
endmodule

// ### sim/lcc_regs_chk.sv
// concurrent checks on the register bank ports, channel 0 vectors
// bound into every lcc_regs instance; one clock, synchronous active-low reset
`timescale 1ns/1ps
module lcc_regs_chk #(
   parameter int NUM_CH = 22
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic [31:0] rdata,
   // pins and channel state
   input wire logic standard_select_hw_enable_pin,
   input wire logic standard_select_hw_e1_pin,
   input wire logic [NUM_CH-1:0] ch_soft_reset,
   input wire logic [NUM_CH-1:0] ch_e1_mode,
   // attenuator controls
   input wire logic [NUM_CH-1:0] tx_atten_enable,
   input wire logic [NUM_CH-1:0] tx_atten_limit_enable,
   input wire logic [NUM_CH*8-1:0] tx_atten_fifo_depth,
   input wire logic [NUM_CH*8-1:0] tx_atten_high_mark,
   input wire logic [NUM_CH-1:0] rx_atten_enable
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   rst_len_a: assert property ($rose(ch_soft_reset[0]) |-> ##199 ch_soft_reset[0] ##1 !ch_soft_reset[0])
      else $error("channel reset length wrong");
   rst_gate_a: assert property (ch_soft_reset[0] && $past(ch_soft_reset[0]) |-> !tx_atten_enable[0] && !rx_atten_enable[0])
      else $error("attenuator enabled during channel reset");
   // four samples cover the two-flop pin synchroniser
   hw_std_a: assert property ((standard_select_hw_enable_pin && standard_select_hw_e1_pin) [*4] |-> ch_e1_mode[0])
      else $error("hardware standard select ignored");
   mark_gap_a: assert property (tx_atten_high_mark[7:0] == tx_atten_fifo_depth[7:0] - 8'h02)
      else $error("high mark not two below depth");
   limit_dep_a: assert property (tx_atten_limit_enable[0] |-> tx_atten_enable[0])
      else $error("limit active on disabled attenuator");
   wr_resp_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write response late");
   b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   rd_resp_a: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   rd_high_a: assert property (rvalid |-> rdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
endmodule

bind lcc_regs lcc_regs_chk #(.NUM_CH(NUM_CH)) u_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
   .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rdata(rdata),
   .standard_select_hw_enable_pin(standard_select_hw_enable_pin),
   .standard_select_hw_e1_pin(standard_select_hw_e1_pin), .ch_soft_reset(ch_soft_reset),
   .ch_e1_mode(ch_e1_mode), .tx_atten_enable(tx_atten_enable), .tx_atten_limit_enable(tx_atten_limit_enable),
   .tx_atten_fifo_depth(tx_atten_fifo_depth), .tx_atten_high_mark(tx_atten_high_mark),
   .rx_atten_enable(rx_atten_enable));

// ### sim/line_channel_config_regs_tb_top.sv
// self-checking bench for the register bank, two channels, axi4-lite master tasks
// assumes the bound checker; master samples at the falling edge, drives after rising edges
`timescale 1ns/1ps
module line_channel_config_regs_tb_top;
   import lcc_pkg::*;
   localparam logic [12:0] A_CF0 = 13'h1F04, A_TJ0 = 13'h1F08, A_RJ0 = 13'h1F0C, A_TMR = 13'h0F00;
   localparam logic [12:0] A_CF1 = 13'h0004, A_TJ1 = 13'h0008, A_RJ1 = 13'h000C, A_BAD = 13'h0104;
   logic aclk = 0, aresetn = 0, tick = 0, pin_en = 0, pin_e1 = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [12:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [1:0] soft_rst, e1_mode, tx_en, tx_lim, rx_en, rx_lim;
   logic [15:0] tx_dep, tx_hi, tx_lo, rx_dep, rx_hi, rx_lo;
   logic [19:0] tx_cf, rx_cf;
   logic [7:0] dep;
   logic [9:0] cf;
   int failures = 0, check_count = 0, n;
   always #2.5 aclk = ~aclk;
   lcc_regs #(.NUM_CH(2)) u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .standard_select_hw_enable_pin(pin_en), .standard_select_hw_e1_pin(pin_e1), .second_timer_tick(tick),
      .ch_soft_reset(soft_rst), .ch_e1_mode(e1_mode), .tx_atten_enable(tx_en), .tx_atten_limit_enable(tx_lim),
      .tx_atten_fifo_depth(tx_dep), .tx_atten_high_mark(tx_hi), .tx_atten_low_mark(tx_lo),
      .tx_atten_corner(tx_cf), .rx_atten_enable(rx_en), .rx_atten_limit_enable(rx_lim),
      .rx_atten_fifo_depth(rx_dep), .rx_atten_high_mark(rx_hi), .rx_atten_low_mark(rx_lo),
      .rx_atten_corner(rx_cf));
   task automatic give_verdict;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   task automatic hang(input string what);
      failures++;
      $display("Error at %0t: %s timed out", $time, what);
      give_verdict();
   endtask
   // both channels offered together; each released at the edge it is taken
   task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ah, wh, bh;
      int k;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      bh = 0;
      for (k = 0; k < 100 && !bh; k++) begin
         @(negedge aclk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         bh = bvalid;
         if (bh) cmp(bresp, er, "bresp");
         @(posedge aclk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
         if (bh) bready <= 1'b0;
      end
      if (!bh) hang("write");
   endtask
   task automatic rd(input logic [12:0] a, input logic [7:0] e, input logic [1:0] er);
      logic ah, rh;
      int k;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      rh = 0;
      for (k = 0; k < 100 && !rh; k++) begin
         @(negedge aclk);
         ah = arvalid && arready;
         rh = rvalid;
         if (rh) cmp(rdata, {24'h000000, e}, "rdata");
         if (rh) cmp(rresp, er, "rresp");
         @(posedge aclk);
         if (ah) arvalid <= 1'b0;
         if (rh) rready <= 1'b0;
      end
      if (!rh) hang("read");
   endtask
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_CF0, 8'h00, RESP_OKAY);
      rd(A_TJ0, 8'h00, RESP_OKAY);
      rd(A_RJ0, 8'h00, RESP_OKAY);
      rd(A_RJ1, 8'h00, RESP_OKAY);
      cmp(tx_dep[7:0], DEPTH_128, "reset depth");
      cmp(rx_cf[9:0], CF_T1_WIDE, "reset corner");
      $display("test reset values done");
      wr(A_TJ1, 8'hFF, RESP_OKAY);
      rd(A_TJ1, 8'h1F, RESP_OKAY);
      wr(A_RJ1, 8'hFF, RESP_OKAY);
      rd(A_RJ1, 8'h1F, RESP_OKAY);
      wr(A_CF1, 8'hFD, RESP_OKAY);
      rd(A_CF1, 8'h01, RESP_OKAY);
      rd(A_RJ0, 8'h00, RESP_OKAY);
      $display("test access and reserved bits done");
      for (int m = 0; m < 2; m++) begin
         wr(A_CF0, 8'(m), RESP_OKAY);
         for (int i = 0; i < 8; i++) begin
            wr(A_TJ0, 8'h18 | 8'(i), RESP_OKAY);
            wr(A_RJ0, 8'(i), RESP_OKAY);
            repeat (2) @(negedge aclk);
            dep = i[2] ? DEPTH_32 : (i[1] ? DEPTH_64 : DEPTH_128);
            cf = i[0] ? (m[0] ? CF_E1_NARROW : CF_T1_NARROW) : (m[0] ? CF_E1_WIDE : CF_T1_WIDE);
            cmp(e1_mode[0], m[0], "mode");
            cmp({tx_dep[7:0], rx_dep[7:0]}, {dep, dep}, "depth");
            cmp({tx_hi[7:0], tx_lo[7:0]}, {dep - LIMIT_MARGIN, LIMIT_MARGIN}, "tx marks");
            cmp({rx_hi[7:0], rx_lo[7:0]}, {dep - LIMIT_MARGIN, LIMIT_MARGIN}, "rx marks");
            cmp({tx_cf[9:0], rx_cf[9:0]}, {cf, cf}, "corner");
            cmp({tx_en[0], tx_lim[0], rx_en[0], rx_lim[0]}, 4'hC, "enables");
         end
      end
      $display("test attenuator settings done");
      @(posedge aclk);
      pin_en <= 1'b1;
      repeat (4) @(negedge aclk);
      cmp(e1_mode[0], 1'b0, "pin mode t1");
      @(posedge aclk);
      pin_e1 <= 1'b1;
      wr(A_CF0, 8'h00, RESP_OKAY);
      repeat (4) @(negedge aclk);
      cmp(e1_mode[0], 1'b1, "pin mode e1");
      @(posedge aclk);
      pin_en <= 1'b0;
      repeat (4) @(negedge aclk);
      cmp(e1_mode[0], 1'b0, "bit mode");
      $display("test standard pins done");
      wr(A_TJ1, 8'h0A, RESP_OKAY);
      wr(A_TJ0, 8'h1F, RESP_OKAY);
      wr(A_CF0, 8'h03, RESP_OKAY);
      rd(A_CF0, 8'h03, RESP_OKAY);
      cmp({soft_rst, tx_en[0]}, 3'h2, "reset confined");
      for (n = 0; n < 300 && soft_rst[0]; n++) @(negedge aclk);
      if (soft_rst[0]) hang("channel reset");
      cmp(n < 200, 1'b1, "reset length");
      rd(A_CF0, 8'h01, RESP_OKAY);
      rd(A_TJ0, 8'h00, RESP_OKAY);
      rd(A_TJ1, 8'h0A, RESP_OKAY);
      cmp({tx_en[1], tx_lim[1], e1_mode[1], tx_dep[15:8]}, {3'h5, DEPTH_64}, "ch1 tx");
      cmp({rx_en[1], rx_lim[1], rx_dep[15:8]}, {2'h3, DEPTH_32}, "ch1 rx");
      cmp({tx_cf[19:10], rx_cf[19:10]}, {CF_E1_WIDE, CF_E1_NARROW}, "ch1 corner");
      $display("test channel reset done");
      rd(A_BAD, 8'h00, RESP_DECERR);
      wr(A_BAD, 8'hFF, RESP_DECERR);
      rd(A_CF1, 8'h01, RESP_OKAY);
      @(posedge aclk);
      tick <= 1'b1;
      @(posedge aclk);
      tick <= 1'b0;
      rd(A_TMR, 8'h01, RESP_OKAY);
      wr(A_TMR, 8'h01, RESP_OKAY);
      rd(A_TMR, 8'h00, RESP_OKAY);
      $display("test map and timer done");
      give_verdict();
   end
endmodule
